// File: gp5_top.sv
// Decided for this implementation: register access over APB.
`include "gp5_consts.svh"

module gp5_top
  import gp5_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [`GP5_NUM_PINS-1:0] pin_in,
  output logic      [`GP5_NUM_PINS-1:0] pin_out,
  output logic      [`GP5_NUM_PINS-1:0] pin_oe_n,
  input  wire logic [`GP5_NUM_PINS-1:0] gpio_out_data,
  output logic      [`GP5_NUM_PINS-1:0] gpio_in_data,
  output logic                          irq3_req,
  output logic                          irq4_req,
  output logic                          irq5_req,
  output logic                          irq7_req,
  output logic                          irq9_req,
  output logic                          irq10_req
);
  localparam int NPINS = `GP5_NUM_PINS;

  localparam logic [`GP5_IDX_W-1:0] PIN_IDX [NPINS] = '{
    `GP5_IDX_PIN0,
    `GP5_IDX_PIN1,
    `GP5_IDX_PIN2,
    `GP5_IDX_PIN3,
    `GP5_IDX_PIN4,
    `GP5_IDX_PIN5
  };

  gp5_apb_state_type   state_reg;
  gp5_apb_state_type   state_next;
  logic [ADDR_W-3:0]   word_idx;
  logic                aligned;
  logic                hit;
  logic [NPINS-1:0]    sel;
  logic [7:0]          rd_byte;
  logic                setup_phase;
  logic                access_phase;
  logic                wr_take;
  logic [NPINS-1:0]    pin_sync;
  logic [NPINS-1:0]    irq_req;

  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  // Zero wait states; the lower byte lane carries the whole register
  assign wr_take      = access_phase && pwrite && pstrb[0];

  always_comb begin
    word_idx = paddr[ADDR_W-1:2];
    aligned  = paddr[1:0] == 2'h0;
    hit      = 1'b0;
    sel      = '0;
    rd_byte  = 8'h00;
    for (int i = 0; i < NPINS; i++) begin
      if (aligned && word_idx == (ADDR_W-2)'(PIN_IDX[i])) begin
        hit     = 1'b1;
        sel[i]  = 1'b1;
        rd_byte = state_reg.ctrl[i];
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    // Read data is captured in setup so prdata comes from a flop
    if (setup_phase) begin
      state_next.prdata  = {24'h000000, rd_byte};
      state_next.pslverr = !hit;
    end
    for (int i = 0; i < NPINS; i++) begin
      if (wr_take && sel[i]) begin
        state_next.ctrl[i] = pwdata[7:0] & `GP5_CTRL_KEEP;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.ctrl    <= {NPINS{`GP5_CTRL_RESET}};
      state_reg.prdata  <= 32'h00000000;
      state_reg.pslverr <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata  = state_reg.prdata;
  assign pslverr = state_reg.pslverr;
  assign pready  = 1'b1;

  // Pins are asynchronous to pclk
  gp5_sync #(
    .WIDTH (NPINS)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  gp5_pin_if pin_bus [NPINS] ();

  for (genvar g = 0; g < NPINS; g++) begin : g_pin
    assign pin_bus[g].ctrl      = state_reg.ctrl[g];
    assign pin_bus[g].pin_level = pin_sync[g];
    assign pin_bus[g].out_data  = gpio_out_data[g];
    assign gpio_in_data[g]      = pin_bus[g].in_value;
    assign irq_req[g]           = pin_bus[g].irq;
    assign pin_out[g]           = pin_bus[g].pin_out;
    assign pin_oe_n[g]          = pin_bus[g].pin_oe_n;

    gp5_pin_ctrl u_pin (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (pin_bus[g].pin)
    );
  end

  assign irq3_req  = irq_req[0];
  assign irq4_req  = irq_req[1];
  assign irq5_req  = irq_req[2];
  assign irq7_req  = irq_req[3];
  assign irq9_req  = irq_req[4];
  assign irq10_req = irq_req[5];

  sequence seq_setup_mapped;
    setup_phase && hit;
  endsequence

  sequence seq_setup_unmapped;
    setup_phase && !hit;
  endsequence

  // Misaligned words are refused like unmapped ones
  sequence seq_setup_misaligned;
    setup_phase && !aligned;
  endsequence

  sequence seq_access;
    access_phase && pready;
  endsequence

  for (genvar g = 0; g < NPINS; g++) begin : g_chk
    // Register leaves reset at default
    chk_ctrl_reset: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(presetn) |-> state_reg.ctrl[g] == `GP5_CTRL_RESET)
      else $error("control register not at reset value");

    chk_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
      wr_take && sel[g] |=> state_reg.ctrl[g] == ($past(pwdata[7:0]) & `GP5_CTRL_KEEP))
      else $error("pin control write not stored");

    // Only the addressed register moves
    chk_write_only_sel: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_take && sel[g]) |=> $stable(state_reg.ctrl[g]))
      else $error("unaddressed control register changed");

    chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg.ctrl[g][6:4] == 3'h0)
      else $error("reserved control bits are not zero");

    chk_read_word: assert property (@(posedge pclk) disable iff (!presetn)
      setup_phase && sel[g] ##1 seq_access |-> prdata == {24'h000000, $past(state_reg.ctrl[g])})
      else $error("read data differs from addressed register");

    chk_polarity_in: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn, 3) && $stable(state_reg.ctrl[g][`GP5_BIT_POL])
      |-> gpio_in_data[g] == ($past(pin_in[g], 3) ^ $past(state_reg.ctrl[g][`GP5_BIT_POL])))
      else $error("input value not polarity adjusted");

    chk_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn, 3) && state_reg.ctrl[g][3:2] == `GP5_FUNC_IRQ
      && $stable(state_reg.ctrl[g]) && $stable(pin_sync[g])
      |=> irq_req[g] == $past(pin_sync[g] ^ state_reg.ctrl[g][`GP5_BIT_POL]))
      else $error("request line does not follow pin");

    chk_reserved_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg.ctrl[g][`GP5_FUNC_LSB] |=> !irq_req[g])
      else $error("reserved function code raised a request");

    chk_pin_input: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg.ctrl[g][`GP5_BIT_DIR] |=> pin_oe_n[g] && !pin_out[g])
      else $error("input pin drives its output");

    chk_pin_pushpull: assert property (@(posedge pclk) disable iff (!presetn)
      !state_reg.ctrl[g][`GP5_BIT_DIR] && !state_reg.ctrl[g][`GP5_BIT_ODRAIN]
      |=> !pin_oe_n[g] && pin_out[g] == $past(gpio_out_data[g] ^ state_reg.ctrl[g][`GP5_BIT_POL]))
      else $error("push-pull pin not driving data");

    chk_pin_odrain: assert property (@(posedge pclk) disable iff (!presetn)
      !state_reg.ctrl[g][`GP5_BIT_DIR] && state_reg.ctrl[g][`GP5_BIT_ODRAIN]
      |=> !pin_out[g] && pin_oe_n[g] == $past(gpio_out_data[g] ^ state_reg.ctrl[g][`GP5_BIT_POL]))
      else $error("open drain pin drives wrong level");
  end

  chk_read_data: assert property (@(posedge pclk) disable iff (!presetn)
    seq_setup_mapped ##1 seq_access |-> !pslverr
    && prdata == {24'h000000, $past(rd_byte)} && prdata[6:4] == 3'h0)
    else $error("read data wrong for mapped register");

  // Unmapped answered with error
  chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    seq_setup_unmapped ##1 seq_access |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not answered with error");

  // Misaligned answered with error
  chk_misaligned_err: assert property (@(posedge pclk) disable iff (!presetn)
    seq_setup_misaligned ##1 seq_access |-> pslverr && prdata == 32'h00000000)
    else $error("misaligned access not answered with error");

  // Unmapped write ignored
  chk_unmapped_keep: assert property (@(posedge pclk) disable iff (!presetn)
    wr_take && !hit |=> $stable(state_reg.ctrl))
    else $error("unmapped write changed a register");

  // Low lane off means no store
  chk_strobe_gate: assert property (@(posedge pclk) disable iff (!presetn)
    access_phase && pwrite && !pstrb[0] |=> $stable(state_reg.ctrl))
    else $error("write without low strobe changed a register");

  chk_irq3_gate: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.ctrl[0][3:2] != `GP5_FUNC_IRQ |=> !irq3_req)
    else $error("line 3 active without request function");

  chk_irq4_gate: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.ctrl[1][3:2] != `GP5_FUNC_IRQ |=> !irq4_req)
    else $error("line 4 active without request function");

  chk_irq5_gate: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.ctrl[2][3:2] != `GP5_FUNC_IRQ |=> !irq5_req)
    else $error("line 5 active without request function");

  chk_irq7_gate: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.ctrl[3][3:2] != `GP5_FUNC_IRQ |=> !irq7_req)
    else $error("line 7 active without request function");

  chk_irq9_gate: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.ctrl[4][3:2] != `GP5_FUNC_IRQ |=> !irq9_req)
    else $error("line 9 active without request function");

  chk_irq10_gate: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.ctrl[5][3:2] != `GP5_FUNC_IRQ |=> !irq10_req)
    else $error("line 10 active without request function");

  chk_dir_output: assert property (@(posedge pclk) disable iff (!presetn)
    !state_reg.ctrl[0][`GP5_BIT_DIR] && !state_reg.ctrl[0][`GP5_BIT_ODRAIN]
    ##1 !state_reg.ctrl[0][`GP5_BIT_DIR] |-> !pin_oe_n[0])
    else $error("output pin 0 not driving");
endmodule : gp5_top

// File: gp5_consts.svh
`ifndef GP5_CONSTS_SVH
`define GP5_CONSTS_SVH

`define GP5_NUM_PINS 6
`define GP5_IDX_W 10
// Register indices; byte address is four times the index
`define GP5_IDX_PIN0 10'h03f
`define GP5_IDX_PIN1 10'h040
`define GP5_IDX_PIN2 10'h041
`define GP5_IDX_PIN3 10'h042
`define GP5_IDX_PIN4 10'h043
`define GP5_IDX_PIN5 10'h044

`define GP5_BIT_DIR 0
`define GP5_BIT_POL 1
`define GP5_FUNC_LSB 2
`define GP5_FUNC_MSB 3
`define GP5_BIT_ODRAIN 7
`define GP5_FUNC_GPIO 2'h0
`define GP5_FUNC_IRQ 2'h2

`define GP5_CTRL_RESET 8'h01
`define GP5_CTRL_KEEP 8'h8f

`endif

// File: gp5_pkg.sv
`include "gp5_consts.svh"

package gp5_pkg;

  typedef logic [7:0] gp5_ctrl_type;

  typedef struct packed {
    gp5_ctrl_type [`GP5_NUM_PINS-1:0] ctrl;
    logic [31:0]                      prdata;
    logic                             pslverr;
  } gp5_apb_state_type;

  typedef struct packed {
    logic irq;
    logic pin_out;
    logic pin_oe_n;
    logic in_value;
  } gp5_pin_state_type;

endpackage : gp5_pkg

// File: gp5_pin_if.sv
interface gp5_pin_if;
  import gp5_pkg::*;

  gp5_ctrl_type ctrl;
  logic         pin_level;
  logic         out_data;
  logic         in_value;
  logic         irq;
  logic         pin_out;
  logic         pin_oe_n;

  modport owner (
    output ctrl,
    output pin_level,
    output out_data,
    input  in_value,
    input  irq,
    input  pin_out,
    input  pin_oe_n
  );

  modport pin (
    input  ctrl,
    input  pin_level,
    input  out_data,
    output in_value,
    output irq,
    output pin_out,
    output pin_oe_n
  );
endinterface : gp5_pin_if

// File: gp5_sync.sv
module gp5_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } gp5_sync_state_type;

  gp5_sync_state_type state_reg;
  gp5_sync_state_type state_next;

  // First stage feeds only the second stage
  always_comb begin
    state_next.stage1 = async_in;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stage2;

  chk_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn, 2) |-> sync_out == $past(async_in, 2))
    else $error("synchroniser output is not input delayed by two");
endmodule : gp5_sync

// File: gp5_pin_ctrl.sv
`include "gp5_consts.svh"

module gp5_pin_ctrl
  import gp5_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  gp5_pin_if.pin    bus
);
  gp5_pin_state_type state_reg;
  gp5_pin_state_type state_next;
  logic              is_input;
  logic              is_irq;
  logic              level;
  logic              drive;

  always_comb begin
    is_input = bus.ctrl[`GP5_BIT_DIR];
    // function decode; reserved codes act as plain mode
    is_irq = bus.ctrl[`GP5_FUNC_MSB:`GP5_FUNC_LSB] == `GP5_FUNC_IRQ;
    level = bus.pin_level ^ bus.ctrl[`GP5_BIT_POL];
    drive = bus.out_data ^ bus.ctrl[`GP5_BIT_POL];
    state_next          = state_reg;
    state_next.in_value = level;
    state_next.irq      = is_irq & level;
    if (is_input) begin
      state_next.pin_out  = 1'b0;
      state_next.pin_oe_n = 1'b1;
    end else if (bus.ctrl[`GP5_BIT_ODRAIN]) begin
      state_next.pin_out  = 1'b0;
      state_next.pin_oe_n = drive;
    end else begin
      state_next.pin_out  = drive;
      state_next.pin_oe_n = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '{irq: 1'b0, pin_out: 1'b0, pin_oe_n: 1'b1, in_value: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign bus.in_value = state_reg.in_value;
  assign bus.irq      = state_reg.irq;
  assign bus.pin_out  = state_reg.pin_out;
  assign bus.pin_oe_n = state_reg.pin_oe_n;

  chk_input_released: assert property (@(posedge pclk) disable iff (!presetn)
    bus.ctrl[`GP5_BIT_DIR] |=> bus.pin_oe_n)
    else $error("input pin is driven");
  chk_odrain_low_only: assert property (@(posedge pclk) disable iff (!presetn)
    !bus.ctrl[`GP5_BIT_DIR] && bus.ctrl[`GP5_BIT_ODRAIN]
    |=> !bus.pin_out && bus.pin_oe_n == $past(bus.out_data ^ bus.ctrl[`GP5_BIT_POL]))
    else $error("open drain output drives wrong level");
  chk_pushpull_drive: assert property (@(posedge pclk) disable iff (!presetn)
    !bus.ctrl[`GP5_BIT_DIR] && !bus.ctrl[`GP5_BIT_ODRAIN]
    |=> !bus.pin_oe_n && bus.pin_out == $past(bus.out_data ^ bus.ctrl[`GP5_BIT_POL]))
    else $error("push-pull output not driving data");
  chk_reserved_func: assert property (@(posedge pclk) disable iff (!presetn)
    bus.ctrl[`GP5_FUNC_LSB] |=> !bus.irq)
    else $error("reserved function raised a request");
endmodule : gp5_pin_ctrl

// File: gp5_pin_model.sv
`include "gp5_consts.svh"

module gp5_pin_model (
  input  wire logic [`GP5_NUM_PINS-1:0] pin_out,
  input  wire logic [`GP5_NUM_PINS-1:0] pin_oe_n,
  input  wire logic [`GP5_NUM_PINS-1:0] ext_level,
  input  wire logic [`GP5_NUM_PINS-1:0] ext_en,
  output logic      [`GP5_NUM_PINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Board pull-up sets the level where nobody drives, so open drain reads high
  always_comb begin
    for (int i = 0; i < `GP5_NUM_PINS; i++) begin
      if (pin_oe_n[i] == 1'b0)
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_level[i];
      else
        pin_in[i] = 1'b1;
    end
  end
endmodule : gp5_pin_model

// File: test_gp5_top.sv
`include "gp5_consts.svh"

module test_gp5_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int NP = `GP5_NUM_PINS;

  logic          pclk = 1'b0;
  logic          presetn;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [11:0]   paddr;
  logic [31:0]   pwdata;
  logic [3:0]    pstrb;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [NP-1:0] pin_in;
  logic [NP-1:0] pin_out;
  logic [NP-1:0] pin_oe_n;
  logic [NP-1:0] gpio_out_data;
  logic [NP-1:0] gpio_in_data;
  logic [NP-1:0] ext_level;
  logic [NP-1:0] ext_en;
  logic [NP-1:0] irq_vec;
  int            bad_count = 0;
  int            tests_run = 0;

  always #20 pclk = ~pclk;

  gp5_top #(.ADDR_W(12)) i_gp5_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .gpio_out_data(gpio_out_data), .gpio_in_data(gpio_in_data),
    .irq3_req(irq_vec[0]), .irq4_req(irq_vec[1]), .irq5_req(irq_vec[2]),
    .irq7_req(irq_vec[3]), .irq9_req(irq_vec[4]), .irq10_req(irq_vec[5])
  );

  gp5_pin_model i_gp5_pin_model (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level), .ext_en(ext_en), .pin_in(pin_in)
  );

  task automatic summarize;
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [NP-1:0] got, input logic [NP-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_pin

  task automatic chk_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_flag

  function automatic logic [11:0] reg_addr(input int i);
    return {10'(`GP5_IDX_PIN0 + i), 2'b00};
  endfunction : reg_addr

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, 4'h0, rd, err);
    chk_reg(rd, exp);
    chk_flag(err, exp_err);
  endtask : rd_chk

  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, 4'hf, rd, err);
    chk_flag(err, exp_err);
  endtask : wr_chk

  task automatic wr_all(input logic [31:0] d, input logic [3:0] st);
    logic [31:0] rd;
    logic        err;
    for (int i = 0; i < NP; i++)
      apb(1'b1, reg_addr(i), d, st, rd, err);
  endtask : wr_all

  // Pin path latency is three edges; five leaves margin for the write
  task automatic settle;
    repeat (5) @(posedge pclk);
    #1;
  endtask : settle

  task automatic drive_ext(input logic [NP-1:0] lvl, input logic [NP-1:0] en, input logic [NP-1:0] od);
    @(posedge pclk);
    ext_level     <= lvl;
    ext_en        <= en;
    gpio_out_data <= od;
  endtask : drive_ext

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    gpio_out_data = '0;
    ext_level = '0;
    ext_en = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < NP; i++) rd_chk(reg_addr(i), 32'h01, 1'b0);
    chk_pin(pin_oe_n, 6'h3f);
    chk_pin(gpio_in_data, 6'h3f);
    chk_pin(irq_vec, 6'h00);
    wr_all(32'hffffffff, 4'he);
    for (int i = 0; i < NP; i++) rd_chk(reg_addr(i), 32'h01, 1'b0);
    wr_all(32'hffffffff, 4'hf);
    // Refused writes must leave every register alone
    wr_chk(12'h114, 32'h00, 1'b1);
    wr_chk(12'h0fd, 32'h00, 1'b1);
    for (int i = 0; i < NP; i++) rd_chk(reg_addr(i), 32'h8f, 1'b0);
    rd_chk(12'h114, 32'h0, 1'b1);
    rd_chk(12'h0f8, 32'h0, 1'b1);
    rd_chk(12'h101, 32'h0, 1'b1);
    // Input with reserved bits set: they must not disturb the pin
    wr_all(32'h71, 4'hf);
    drive_ext(6'h25, 6'h3f, 6'h00);
    settle();
    chk_pin(pin_oe_n, 6'h3f);
    chk_pin(gpio_in_data, 6'h25);
    wr_all(32'h73, 4'hf);
    settle();
    chk_pin(gpio_in_data, 6'h1a);
    drive_ext(6'h00, 6'h00, 6'h2d);
    wr_all(32'h00, 4'hf);
    settle();
    chk_pin(pin_oe_n, 6'h00);
    chk_pin(pin_out, 6'h2d);
    wr_all(32'h02, 4'hf);
    settle();
    chk_pin(pin_out, 6'h12);
    wr_all(32'h80, 4'hf);
    settle();
    chk_pin(pin_out, 6'h00);
    chk_pin(pin_oe_n, 6'h2d);
    chk_pin(gpio_in_data, 6'h2d);
    wr_all(32'h09, 4'hf);
    for (int i = 0; i < NP; i++) begin
      drive_ext(6'(1 << i), 6'h3f, 6'h00);
      settle();
      chk_pin(irq_vec, 6'(1 << i));
    end
    wr_all(32'h0b, 4'hf);
    drive_ext(6'h0c, 6'h3f, 6'h00);
    settle();
    chk_pin(irq_vec, 6'h33);
    // Request mode keeps the driver when the pin is an output
    drive_ext(6'h00, 6'h00, 6'h15);
    wr_all(32'h08, 4'hf);
    settle();
    chk_pin(pin_out, 6'h15);
    chk_pin(irq_vec, 6'h15);
    drive_ext(6'h3f, 6'h3f, 6'h00);
    for (int k = 0; k < 3; k++) begin
      wr_all(k == 0 ? 32'h01 : (k == 1 ? 32'h05 : 32'h0d), 4'hf);
      settle();
      chk_pin(irq_vec, 6'h00);
      chk_pin(gpio_in_data, 6'h3f);
    end
    summarize();
  end
endmodule : test_gp5_top
